//--- rtl/gnc_limit_checker.sv
// Go/no-good limit store and window comparator of the electronic load
// Summary of operation
// - A pair whose lower bound would exceed its upper bound is refused.
// - Current upper and lower limits are writable and readable.
// - Current window applies only in constant-current or constant-resistance mode.
// - Current below the lower limit raises no-good.
// - Current above the upper limit raises no-good.
// - Current inside its window raises no current failure.
// - Power upper and lower limits are accepted from the host.
// - Power window applies only in constant-power or constant-resistance mode.
// - Power below the lower limit raises no-good.
// - Power above the upper limit raises no-good.
// - Power inside its window raises no power failure.
// - Terminal voltage has a writable, readable upper and lower limit pair.
// - Voltage below the lower limit raises no-good.
// - Voltage above the upper limit raises no-good.
// - Short test has its own voltage pair, checked only while the test runs.
// - No-good query answers 1 while the flag is present, 0 otherwise.
`timescale 1ns/10ps
module gnc_limit_checker #(
  parameter int DATA_W = gnc_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [gnc_pkg::SEL_W-1:0] wr_sel,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [gnc_pkg::SEL_W-1:0] rd_sel,
  input wire logic [gnc_pkg::MODE_W-1:0] op_mode,
  input wire logic short_test_active,
  input wire logic [DATA_W-1:0] meas_current,
  input wire logic [DATA_W-1:0] meas_power,
  input wire logic [DATA_W-1:0] meas_voltage,
  output logic [DATA_W-1:0] rd_data,
  output logic wr_refused,
  output logic current_fail,
  output logic power_fail,
  output logic voltage_fail,
  output logic short_fail,
  output logic no_good_flag,
  output logic no_good_answer
);
  import gnc_pkg::*;

  typedef struct packed {
    logic [NUM_LIMITS-1:0][DATA_W-1:0] lim;
    logic [DATA_W-1:0] rd_data;
    logic wr_refused;
    logic current_fail;
    logic power_fail;
    logic voltage_fail;
    logic short_fail;
    logic no_good;
  } gnc_state_t;

  gnc_state_t st;
  gnc_state_t next_st;

  function automatic logic uses_current(input logic [MODE_W-1:0] m);
    return (m == CONSTANT_CURRENT_OPERATION) || (m == CONSTANT_RESISTANCE_OPERATION);
  endfunction

  function automatic logic uses_power(input logic [MODE_W-1:0] m);
    return (m == CONSTANT_POWER_OPERATION) || (m == CONSTANT_RESISTANCE_OPERATION);
  endfunction

  function automatic logic outside(input logic [DATA_W-1:0] v,
                                   input logic [DATA_W-1:0] lo,
                                   input logic [DATA_W-1:0] hi);
    return (v < lo) || (v > hi);
  endfunction

  // Partner of a limit within its pair: flip the low index bit
  logic [SEL_W-1:0] partner_sel;
  logic write_ok;
  logic cur_out;
  logic pwr_out;
  logic vlt_out;
  logic sht_out;

  assign partner_sel = {wr_sel[SEL_W-1:1], ~wr_sel[0]};
  // Upper limits sit at even indices, so bit 0 tells which side is being written
  assign write_ok = wr_sel[0] ? (wr_data <= st.lim[partner_sel])
                              : (wr_data >= st.lim[partner_sel]);

  assign cur_out = uses_current(op_mode) &&
                   outside(meas_current, st.lim[CURRENT_LOWER_LIMIT],
                           st.lim[CURRENT_UPPER_LIMIT]);
  assign pwr_out = uses_power(op_mode) &&
                   outside(meas_power, st.lim[POWER_LOWER_LIMIT],
                           st.lim[POWER_UPPER_LIMIT]);
  assign vlt_out = outside(meas_voltage, st.lim[VOLTAGE_LOWER_LIMIT],
                           st.lim[VOLTAGE_UPPER_LIMIT]);
  assign sht_out = short_test_active &&
                   outside(meas_voltage, st.lim[SHORT_TEST_VOLTAGE_LOWER],
                           st.lim[SHORT_TEST_VOLTAGE_UPPER]);

  always_comb begin
    next_st = st;
    next_st.wr_refused = 1'h0;
    if (wr_en) begin
      if (write_ok) begin
        next_st.lim[wr_sel] = wr_data;
      end else begin
        // The old pair is kept whole; software sees the refusal pulse
        next_st.wr_refused = 1'h1;
      end
    end
    // Read-back shows the stored value, before any write in the same cycle
    next_st.rd_data = st.lim[rd_sel];
    next_st.current_fail = cur_out;
    next_st.power_fail = pwr_out;
    next_st.voltage_fail = vlt_out;
    next_st.short_fail = sht_out;
    next_st.no_good = cur_out || pwr_out || vlt_out || sht_out;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_LIMITS; i++) begin
        st.lim[i] <= (i % 2 == 0) ? {DATA_W{UPPER_RST_FILL}} : {DATA_W{LOWER_RST_FILL}};
      end
      st.rd_data <= '0;
      st.wr_refused <= 1'h0;
      st.current_fail <= 1'h0;
      st.power_fail <= 1'h0;
      st.voltage_fail <= 1'h0;
      st.short_fail <= 1'h0;
      st.no_good <= 1'h0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign wr_refused = st.wr_refused;
  assign current_fail = st.current_fail;
  assign power_fail = st.power_fail;
  assign voltage_fail = st.voltage_fail;
  assign short_fail = st.short_fail;
  assign no_good_flag = st.no_good;
  assign no_good_answer = st.no_good ? NO_GOOD_ANSWER_PRESENT : NO_GOOD_ANSWER_ABSENT;

  // Next-cycle checks other than chk_frozen_state gate their antecedent with clk_en, since frozen edges move no state
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_pair_order_kept: assert property (
    (st.lim[CURRENT_LOWER_LIMIT] <= st.lim[CURRENT_UPPER_LIMIT]) &&
    (st.lim[POWER_LOWER_LIMIT] <= st.lim[POWER_UPPER_LIMIT]) &&
    (st.lim[VOLTAGE_LOWER_LIMIT] <= st.lim[VOLTAGE_UPPER_LIMIT]) &&
    (st.lim[SHORT_TEST_VOLTAGE_LOWER] <= st.lim[SHORT_TEST_VOLTAGE_UPPER]))
    else $error("limit pair holds lower above upper");

  // One order check per pair, so a failure names the pair that broke
  for (genvar p = 0; p < NUM_LIMITS / 2; p++) begin : g_pair_order
    chk_pair_order: assert property (
      st.lim[2 * p + 1] <= st.lim[2 * p])
      else $error("one limit pair holds its lower value above its upper value");
  end

  chk_bad_write_refused: assert property (
    clk_en && wr_en && !write_ok |=> wr_refused && $stable(st.lim))
    else $error("inverted pair write was not refused");

  chk_current_readback: assert property (
    clk_en && wr_en && write_ok && wr_sel == CURRENT_LOWER_LIMIT ##1
    clk_en && rd_sel == CURRENT_LOWER_LIMIT && !(wr_en && wr_sel == CURRENT_LOWER_LIMIT)
    |=> rd_data == $past(wr_data, 2))
    else $error("current limit read-back mismatch");

  chk_current_mode_gate: assert property (
    clk_en && !uses_current(op_mode) |=> !current_fail)
    else $error("current window checked outside its modes");

  chk_current_low_flag: assert property (
    clk_en && uses_current(op_mode) && meas_current < st.lim[CURRENT_LOWER_LIMIT]
    |=> current_fail && no_good_flag)
    else $error("low current missed");

  chk_current_high_flag: assert property (
    clk_en && uses_current(op_mode) && meas_current > st.lim[CURRENT_UPPER_LIMIT]
    |=> current_fail && no_good_flag)
    else $error("high current missed");

  chk_current_inside: assert property (
    clk_en && meas_current >= st.lim[CURRENT_LOWER_LIMIT] &&
    meas_current <= st.lim[CURRENT_UPPER_LIMIT] |=> !current_fail)
    else $error("current fail inside window");

  chk_power_mode_gate: assert property (
    clk_en && !uses_power(op_mode) |=> !power_fail)
    else $error("power window checked outside its modes");

  chk_power_window: assert property (
    clk_en && uses_power(op_mode) |=> power_fail ==
    ($past(meas_power) < $past(st.lim[POWER_LOWER_LIMIT]) ||
     $past(meas_power) > $past(st.lim[POWER_UPPER_LIMIT])))
    else $error("power window result wrong");

  chk_voltage_window: assert property (
    clk_en && (meas_voltage < st.lim[VOLTAGE_LOWER_LIMIT] ||
    meas_voltage > st.lim[VOLTAGE_UPPER_LIMIT]) |=> voltage_fail && no_good_flag)
    else $error("voltage excursion missed");

  chk_short_gate: assert property (
    clk_en && !short_test_active |=> !short_fail)
    else $error("short pair checked with test idle");

  chk_query_answer: assert property (
    no_good_answer == no_good_flag)
    else $error("no-good answer disagrees with flag");

  chk_flag_or_term: assert property (
    no_good_flag == (current_fail || power_fail || voltage_fail || short_fail))
    else $error("no-good is not the OR of window results");

  chk_frozen_state: assert property (
    !clk_en |=> $stable(st))
    else $error("state moved with clock enable low");

  // Refusal checked against the stored partner directly, not through write_ok,
  // so a wrong compare in the write path cannot hide behind its own result
  chk_cur_lower_refused: assert property (
    clk_en && wr_en && wr_sel == CURRENT_LOWER_LIMIT &&
    wr_data > st.lim[CURRENT_UPPER_LIMIT] |=> wr_refused && $stable(st.lim))
    else $error("current lower above upper was stored");

  chk_cur_upper_refused: assert property (
    clk_en && wr_en && wr_sel == CURRENT_UPPER_LIMIT &&
    wr_data < st.lim[CURRENT_LOWER_LIMIT] |=> wr_refused && $stable(st.lim))
    else $error("current upper below lower was stored");

  chk_good_write_quiet: assert property (
    clk_en && wr_en && write_ok |=> !wr_refused)
    else $error("accepted write raised a refusal");

  // The refusal is a pulse, never a level left over from an older write
  chk_refusal_pulse: assert property (
    clk_en && !wr_en |=> !wr_refused)
    else $error("refusal shown without a write");

  // Every accepted write, whatever the pair, reaches the store one edge later
  chk_write_lands: assert property (
    clk_en && wr_en && write_ok |=> st.lim[$past(wr_sel)] == $past(wr_data))
    else $error("accepted limit write did not land");

  chk_power_stored: assert property (
    clk_en && wr_en && write_ok && wr_sel == POWER_LOWER_LIMIT
    |=> st.lim[POWER_LOWER_LIMIT] == $past(wr_data))
    else $error("power lower limit not accepted");

  // Read-back is one cycle late and shows the limit before a same-cycle write
  chk_read_follows_sel: assert property (
    clk_en |=> rd_data == $past(st.lim[rd_sel]))
    else $error("read-back does not show the stored limit");

  // Power window checked one bound at a time, alongside the combined check above
  chk_power_low_flag: assert property (
    clk_en && uses_power(op_mode) && meas_power < st.lim[POWER_LOWER_LIMIT]
    |=> power_fail && no_good_flag)
    else $error("low power missed");

  chk_power_high_flag: assert property (
    clk_en && uses_power(op_mode) && meas_power > st.lim[POWER_UPPER_LIMIT]
    |=> power_fail && no_good_flag)
    else $error("high power missed");

  chk_power_inside: assert property (
    clk_en && meas_power >= st.lim[POWER_LOWER_LIMIT] &&
    meas_power <= st.lim[POWER_UPPER_LIMIT] |=> !power_fail)
    else $error("power fail inside window");

  chk_voltage_inside: assert property (
    clk_en && meas_voltage >= st.lim[VOLTAGE_LOWER_LIMIT] &&
    meas_voltage <= st.lim[VOLTAGE_UPPER_LIMIT] |=> !voltage_fail)
    else $error("voltage fail inside window");

  // Short pair adds to the terminal pair during the test, it never replaces it
  chk_short_window: assert property (
    clk_en && short_test_active &&
    (meas_voltage < st.lim[SHORT_TEST_VOLTAGE_LOWER] ||
     meas_voltage > st.lim[SHORT_TEST_VOLTAGE_UPPER]) |=> short_fail && no_good_flag)
    else $error("short test excursion missed");

  chk_short_inside: assert property (
    clk_en && meas_voltage >= st.lim[SHORT_TEST_VOLTAGE_LOWER] &&
    meas_voltage <= st.lim[SHORT_TEST_VOLTAGE_UPPER] |=> !short_fail)
    else $error("short fail inside short window");

  // Literal answers, so a swapped pair of answer constants is caught
  chk_answer_present: assert property (
    no_good_flag |-> no_good_answer == 1'h1)
    else $error("query answers absent with flag set");

  chk_answer_absent: assert property (
    !no_good_flag |-> no_good_answer == 1'h0)
    else $error("query answers present with flag clear");

  cov_write_refused: cover property (clk_en && wr_en && !write_ok);
  cov_current_fail: cover property (current_fail && no_good_flag);
  cov_short_fail: cover property (short_test_active ##1 short_fail);
  cov_flag_clears: cover property (no_good_flag ##1 !no_good_flag);
  cov_clock_frozen: cover property (!clk_en ##1 !clk_en);
endmodule

//--- pkg/gnc_pkg.sv
// Constants shared by the go/no-good limit checker
package gnc_pkg;
  localparam int DATA_W = 16;
  localparam int NUM_LIMITS = 8;
  localparam int SEL_W = 3;
  localparam int MODE_W = 2;

  // Limit store indices; an upper limit is always even, its lower partner is the next index
  localparam logic [2:0] CURRENT_UPPER_LIMIT = 3'h0;
  localparam logic [2:0] CURRENT_LOWER_LIMIT = 3'h1;
  localparam logic [2:0] POWER_UPPER_LIMIT = 3'h2;
  localparam logic [2:0] POWER_LOWER_LIMIT = 3'h3;
  localparam logic [2:0] VOLTAGE_UPPER_LIMIT = 3'h4;
  localparam logic [2:0] VOLTAGE_LOWER_LIMIT = 3'h5;
  localparam logic [2:0] SHORT_TEST_VOLTAGE_UPPER = 3'h6;
  localparam logic [2:0] SHORT_TEST_VOLTAGE_LOWER = 3'h7;

  // Operating mode codes as reported by the mode query
  localparam logic [1:0] CONSTANT_CURRENT_OPERATION = 2'h0;
  localparam logic [1:0] CONSTANT_RESISTANCE_OPERATION = 2'h1;
  localparam logic [1:0] CONSTANT_VOLTAGE_OPERATION = 2'h2;
  localparam logic [1:0] CONSTANT_POWER_OPERATION = 2'h3;

  // Reset fill: upper limits open fully, lower limits at zero, so nothing fails after reset
  localparam logic UPPER_RST_FILL = 1'h1;
  localparam logic LOWER_RST_FILL = 1'h0;

  // No-good query answers
  localparam logic NO_GOOD_ANSWER_PRESENT = 1'h1;
  localparam logic NO_GOOD_ANSWER_ABSENT = 1'h0;
endpackage

//--- test/gnc_host_model.sv
// Host side model: issues limit writes and read-back selects
`timescale 1ns/10ps
module gnc_host_model (
  input wire logic mclk,
  output logic wr_en,
  output logic [gnc_pkg::SEL_W-1:0] wr_sel,
  output logic [gnc_pkg::DATA_W-1:0] wr_data,
  output logic [gnc_pkg::SEL_W-1:0] rd_sel
);
  import gnc_pkg::*;
  initial begin
    wr_en = 1'h0;
    wr_sel = 3'h0;
    wr_data = 16'h0000;
    rd_sel = 3'h0;
  end
  // Pair order is kept by the caller, except where a refusal is wanted
  task write(input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    #1 wr_en = 1'h1;
    wr_sel = s;
    wr_data = d;
    @(posedge mclk);
    #1 wr_en = 1'h0;
    // Idle data is scrambled so a stale value never looks valid
    wr_data = ~d;
  endtask
  task select(input logic [SEL_W-1:0] s);
    @(posedge mclk);
    #1 rd_sel = s;
    @(posedge mclk);
    #1;
  endtask
endmodule

//--- test/go_nogo_limit_checker_tb.sv
// Self-checking bench for the go/no-good limit checker
`timescale 1ns/10ps
`define CMP(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module go_nogo_limit_checker_tb;
  import gnc_pkg::*;
  localparam logic [15:0] I0 = 16'h0096;
  localparam logic [15:0] P0 = 16'h0018;
  localparam logic [15:0] V0 = 16'h0040;
  int n_checks = 0;
  int n_mismatch = 0;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic wr_en, wr_refused, current_fail, power_fail, voltage_fail, short_fail;
  logic no_good_flag, no_good_answer;
  logic short_test_active = 1'h0;
  logic clk_en = 1'h1;
  logic [SEL_W-1:0] wr_sel, rd_sel;
  logic [MODE_W-1:0] op_mode = 2'h0;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [DATA_W-1:0] meas_current = I0;
  logic [DATA_W-1:0] meas_power = P0;
  logic [DATA_W-1:0] meas_voltage = V0;
  always #10 mclk = ~mclk;
  gnc_host_model gnc_host_model_inst (.mclk(mclk), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .rd_sel(rd_sel));
  gnc_limit_checker #(.DATA_W(DATA_W)) gnc_limit_checker_inst (.mclk(mclk), .rst_b(rst_b),
    .clk_en(clk_en), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel),
    .op_mode(op_mode), .short_test_active(short_test_active), .meas_current(meas_current),
    .meas_power(meas_power), .meas_voltage(meas_voltage), .rd_data(rd_data),
    .wr_refused(wr_refused), .current_fail(current_fail), .power_fail(power_fail),
    .voltage_fail(voltage_fail), .short_fail(short_fail), .no_good_flag(no_good_flag),
    .no_good_answer(no_good_answer));
  task rdchk(input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] e);
    gnc_host_model_inst.select(s);
    `CMP(rd_data, e)
  endtask
  task wrchk(input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] d, input logic r);
    gnc_host_model_inst.write(s, d);
    `CMP(wr_refused, r)
  endtask
  task probe(input logic [1:0] m, input logic st, input logic [15:0] i, p, v,
             input logic [3:0] f);
    @(posedge mclk);
    #1 op_mode = m;
    short_test_active = st;
    meas_current = i;
    meas_power = p;
    meas_voltage = v;
    @(posedge mclk);
    #1;
    `CMP({current_fail, power_fail, voltage_fail, short_fail}, f)
    `CMP({no_good_flag, no_good_answer}, {2{|f}})
  endtask
  task t_store;
    rdchk(CURRENT_UPPER_LIMIT, 16'hffff);
    rdchk(CURRENT_LOWER_LIMIT, 16'h0000);
    wrchk(CURRENT_UPPER_LIMIT, 16'h00c8, 1'h0);
    wrchk(CURRENT_LOWER_LIMIT, 16'h0064, 1'h0);
    wrchk(CURRENT_LOWER_LIMIT, 16'h00c9, 1'h1);
    wrchk(CURRENT_UPPER_LIMIT, 16'h0063, 1'h1);
    rdchk(CURRENT_LOWER_LIMIT, 16'h0064);
    rdchk(CURRENT_UPPER_LIMIT, 16'h00c8);
    wrchk(POWER_UPPER_LIMIT, 16'h0020, 1'h0);
    wrchk(POWER_LOWER_LIMIT, 16'h0010, 1'h0);
    wrchk(VOLTAGE_UPPER_LIMIT, 16'h0050, 1'h0);
    wrchk(VOLTAGE_LOWER_LIMIT, 16'h0030, 1'h0);
    rdchk(VOLTAGE_LOWER_LIMIT, 16'h0030);
    wrchk(SHORT_TEST_VOLTAGE_UPPER, 16'h0048, 1'h0);
    wrchk(SHORT_TEST_VOLTAGE_LOWER, 16'h0048, 1'h0);
    wrchk(SHORT_TEST_VOLTAGE_LOWER, 16'h0038, 1'h0);
    $display("test store done");
  endtask
  task t_current;
    probe(2'h0, 1'h0, 16'h0063, P0, V0, 4'h8);
    probe(2'h0, 1'h0, 16'h00c9, P0, V0, 4'h8);
    probe(2'h0, 1'h0, 16'h0064, P0, V0, 4'h0);
    probe(2'h0, 1'h0, 16'h00c8, P0, V0, 4'h0);
    probe(2'h2, 1'h0, 16'h0063, P0, V0, 4'h0);
    probe(2'h3, 1'h0, 16'h0063, P0, V0, 4'h0);
    probe(2'h1, 1'h0, 16'h00c9, P0, V0, 4'h8);
    $display("test current done");
  endtask
  task t_power;
    probe(2'h3, 1'h0, I0, 16'h000f, V0, 4'h4);
    probe(2'h3, 1'h0, I0, 16'h0021, V0, 4'h4);
    probe(2'h3, 1'h0, I0, 16'h0010, V0, 4'h0);
    probe(2'h0, 1'h0, I0, 16'h0021, V0, 4'h0);
    probe(2'h1, 1'h0, 16'h0063, 16'h000f, V0, 4'hc);
    $display("test power done");
  endtask
  task t_voltage;
    probe(2'h2, 1'h0, I0, P0, 16'h002f, 4'h2);
    probe(2'h2, 1'h0, I0, P0, 16'h0051, 4'h2);
    probe(2'h3, 1'h0, I0, P0, 16'h0030, 4'h0);
    probe(2'h0, 1'h0, I0, P0, 16'h0051, 4'h2);
    $display("test voltage done");
  endtask
  task t_short;
    probe(2'h2, 1'h1, I0, P0, 16'h0034, 4'h1);
    probe(2'h2, 1'h0, I0, P0, 16'h0034, 4'h0);
    probe(2'h2, 1'h1, I0, P0, 16'h004c, 4'h1);
    probe(2'h2, 1'h1, I0, P0, 16'h002f, 4'h3);
    $display("test short done");
  endtask
  // A write made while frozen must not reach the store, and flags must hold
  task t_freeze;
    probe(2'h0, 1'h0, 16'h0063, P0, V0, 4'h8);
    @(posedge mclk);
    #1 clk_en = 1'h0;
    meas_current = I0;
    gnc_host_model_inst.write(CURRENT_LOWER_LIMIT, 16'h0050);
    `CMP({current_fail, no_good_flag, wr_refused}, 3'h6)
    clk_en = 1'h1;
    rdchk(CURRENT_LOWER_LIMIT, 16'h0064);
    probe(2'h0, 1'h0, I0, P0, V0, 4'h0);
    $display("test freeze done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst_b = 1'h1;
    t_store();
    t_current();
    t_power();
    t_voltage();
    t_short();
    t_freeze();
    complete_run();
  end
endmodule
